// >>> logic/pirr_pkg.sv
// Package for the shared request line router: constants, types and reset values
package pirr_pkg;
  localparam int LINE_COUNT = 8;
  localparam int LEGACY_IRQS = 16;
  localparam int ADV_IRQS = 24;
  localparam int ADV_LINE_BASE = 16;
  localparam logic [4:0] IRQ_TIMER = 5'h00;
  localparam logic [4:0] IRQ_KEYBOARD = 5'h01;
  localparam logic [4:0] IRQ_CASCADE = 5'h02;
  localparam logic [4:0] IRQ_RTC = 5'h08;
  localparam logic [4:0] IRQ_COPROC = 5'h0d;
  // Legal steering targets in legacy mode: 3,4,5,6,7,9,10,11,12,14,15
  localparam logic [15:0] LEGACY_STEER_MASK = 16'hdef8;
  localparam logic [3:0] FIRST_SERIAL_DEFAULT = 4'h4;
  localparam logic [3:0] SECOND_SERIAL_DEFAULT = 4'h3;
  localparam logic [3:0] FIRST_PARALLEL_DEFAULT = 4'h7;
  localparam logic [3:0] LINE_STEER_DEFAULT = 4'hb;

  typedef enum logic [0:0] {
    PIRR_MODE_LEGACY = 1'b0,
    PIRR_MODE_ADVANCED = 1'b1
  } pirr_mode_e;

  // Fixed system sources
  typedef struct packed {
    logic timer;
    logic keyboard;
    logic rtc;
    logic coproc;
    logic mouse;
    logic diskette;
    logic ide_primary;
    logic ide_secondary;
  } pirr_fixed_s;

  // Steerable legacy device sources and their targets
  typedef struct packed {
    logic first_serial_port;
    logic second_serial_port;
    logic first_parallel_port;
    logic [3:0] first_serial_irq;
    logic [3:0] second_serial_irq;
    logic [3:0] first_parallel_irq;
  } pirr_port_s;

  // One write to the steering table
  typedef struct packed {
    logic valid;
    logic [2:0] line;
    logic [3:0] irq;
  } pirr_steer_s;
endpackage

// >>> logic/pirr_router.sv
// Shared request line router onto legacy or advanced interrupt numbers
//
// Overview of operation
// [R01] Legacy mode drives only interrupt numbers 0 to 15.
// [R02] Advanced mode provides 24 interrupt numbers, 0 to 23.
// [R03] Eight shared request inputs; every source wires to exactly one of them.
// [R04] Advanced mode puts lines A..H on numbers 16..23; absent in legacy.
// [R05] Legacy steering targets only 3,4,5,6,7,9,10,11,12,14,15.
// [R06] Several lines may steer to one number; requests are merged.
// [R07] Numbers 0,1,2,8,13 reserved for timer, keyboard, cascade, clock, coprocessor.
// [R08] Serial ports default to 4 and 3, parallel to 7; all reprogrammable.
// [R09] All sources on one line appear as the same interrupt number.
// [R10] Steering of on-chip port interrupts is changed at run time.
// [R11] Performance-critical devices should not share a request line.
// [R12] Lines are level sensitive, active low, held while any source requests.
`timescale 1ns/1ps
module pirr_router
  import pirr_pkg::*;
#(
  parameter int LINES = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Mode and steering table writes
  input wire pirr_pkg::pirr_mode_e mode,
  input wire pirr_pkg::pirr_steer_s steer_wr,
  // Shared request lines A..H, active low
  input wire logic [LINES-1:0] shared_request_line_n,
  // Fixed and steerable system sources, active high
  input wire pirr_pkg::pirr_fixed_s fixed_src,
  input wire pirr_pkg::pirr_port_s port_src,
  input wire logic cascade_req,
  // Interrupt numbers to the processor
  output logic [23:0] irq_out,
  output logic [LINES-1:0] line_active,
  output logic steer_err
);
  import pirr_pkg::*;

  // Refuse any line count other than the eight that the fixed advanced window holds
  if (LINES != LINE_COUNT) begin : g_bad_lines
    $error("pirr_router supports exactly eight shared request lines");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line synchroniser

  logic [LINES-1:0] sync1_reg;
  logic [LINES-1:0] sync2_reg;
  logic [LINES-1:0] line_req;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= shared_request_line_n;
      sync2_reg <= sync1_reg;
    end
  end

  // Low level means some wired source still requests
  assign line_req = ~sync2_reg; // R12 R09 R03

  ////////////////////////////////////////////////////////////////////////////
  // Steering table

  function automatic logic steer_legal(input logic [3:0] irq);
    steer_legal = LEGACY_STEER_MASK[irq];
  endfunction

  function automatic logic [15:0] onehot16(input logic [3:0] irq);
    onehot16 = 16'h0001 << irq;
  endfunction

  logic [3:0] steer_reg [LINES];
  logic steer_err_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < LINES; i++) begin
        steer_reg[i] <= LINE_STEER_DEFAULT;
      end
    end else if (steer_wr.valid && steer_legal(steer_wr.irq)) begin // R05 R10
      steer_reg[steer_wr.line] <= steer_wr.irq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      steer_err_reg <= 1'b0;
    end else begin
      steer_err_reg <= steer_wr.valid && !steer_legal(steer_wr.irq);
    end
  end

  assign steer_err = steer_err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt number composition

  logic [15:0] legacy_next;
  logic [23:0] irq_next;
  logic [23:0] irq_reg;
  logic [LINES-1:0] line_active_reg;

  always_comb begin
    legacy_next = 16'h0000;
    legacy_next[IRQ_TIMER[3:0]] = fixed_src.timer; // R07
    legacy_next[IRQ_KEYBOARD[3:0]] = fixed_src.keyboard;
    legacy_next[IRQ_CASCADE[3:0]] = cascade_req;
    legacy_next[IRQ_RTC[3:0]] = fixed_src.rtc;
    legacy_next[IRQ_COPROC[3:0]] = fixed_src.coproc;
    legacy_next[6] = fixed_src.diskette;
    legacy_next[12] = fixed_src.mouse;
    legacy_next[14] = fixed_src.ide_primary;
    legacy_next[15] = fixed_src.ide_secondary;
    // Port targets on reserved numbers are dropped so fixed sources own them alone
    if (port_src.first_serial_port) begin // R08
      legacy_next = legacy_next | (onehot16(port_src.first_serial_irq) & LEGACY_STEER_MASK); // R07
    end
    if (port_src.second_serial_port) begin
      legacy_next = legacy_next | (onehot16(port_src.second_serial_irq) & LEGACY_STEER_MASK); // R07
    end
    if (port_src.first_parallel_port) begin
      legacy_next = legacy_next | (onehot16(port_src.first_parallel_irq) & LEGACY_STEER_MASK); // R07
    end
  end

  always_comb begin
    irq_next = {8'h00, legacy_next};
    if (mode == PIRR_MODE_ADVANCED) begin
      irq_next[ADV_IRQS-1:ADV_LINE_BASE] = line_req; // R02 R04
    end else begin
      for (int i = 0; i < LINES; i++) begin
        if (line_req[i]) begin
          irq_next[15:0] = irq_next[15:0] | onehot16(steer_reg[i]); // R05 R06
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 24'h000000;
      line_active_reg <= '0;
    end else begin
      irq_reg <= irq_next; // R01
      line_active_reg <= line_req;
    end
  end

  assign irq_out = irq_reg;
  assign line_active = line_active_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  legacy_upper_zero_a: assert property (@(posedge clk) disable iff (rst) // R01
    $past(mode) == PIRR_MODE_LEGACY |-> irq_out[23:16] == 8'h00)
    else $error("legacy mode drove a number above 15");

  adv_line_map_a: assert property (@(posedge clk) disable iff (rst) // R04
    mode == PIRR_MODE_ADVANCED |=> irq_out[23:16] == $past(line_req))
    else $error("advanced line mapping wrong");

  adv_count_a: assert property (@(posedge clk) disable iff (rst) // R02
    (mode == PIRR_MODE_ADVANCED && !shared_request_line_n[7]) [*3] |-> ##1 irq_out[23])
    else $error("line H missing on number 23");

  steer_legal_a: assert property (@(posedge clk) disable iff (rst) // R05
    steer_wr.valid && !LEGACY_STEER_MASK[steer_wr.irq] |=> steer_err && $stable(steer_reg[0]))
    else $error("illegal steering accepted");

  merge_lines_a: assert property (@(posedge clk) disable iff (rst) // R06
    mode == PIRR_MODE_LEGACY && line_req[2] && line_req[3] |=>
    irq_out[$past(steer_reg[2])] && irq_out[$past(steer_reg[3])])
    else $error("merged line lost");

  reserved_timer_a: assert property (@(posedge clk) disable iff (rst) // R07
    fixed_src.timer |=> irq_out[0])
    else $error("timer not on number 0");

  serial_default_a: assert property (@(posedge clk) disable iff (rst) // R08
    port_src.first_serial_port && port_src.first_serial_irq == FIRST_SERIAL_DEFAULT |=> irq_out[4])
    else $error("first serial port not delivered");

  line_level_a: assert property (@(posedge clk) disable iff (rst) // R12
    !shared_request_line_n[0] [*3] |-> ##1 line_active[0])
    else $error("active low line not seen");

  line_idle_a: assert property (@(posedge clk) disable iff (rst) // R09
    shared_request_line_n[2] [*4] |-> !line_active[2])
    else $error("idle line reported active");

  // Steering may be rewritten in the cycle a line requests, so the old target is used
  steer_write_a: assert property (@(posedge clk) disable iff (rst) // R10
    steer_wr.valid && LEGACY_STEER_MASK[steer_wr.irq] |=>
    steer_reg[$past(steer_wr.line)] == $past(steer_wr.irq))
    else $error("legal steering write lost");

  steer_err_pulse_a: assert property (@(posedge clk) disable iff (rst) // R05
    !steer_wr.valid |=>
    !steer_err)
    else $error("error pulse without a write");

  line_active_map_a: assert property (@(posedge clk) disable iff (rst) // R12
    1'b1 |=>
    line_active == $past(line_req))
    else $error("line state not registered");

  reset_clear_a: assert property (@(posedge clk) // R01
    rst |=>
    irq_out == 24'h000000 && line_active == '0 && !steer_err)
    else $error("outputs not cleared by reset");

  timer_quiet_a: assert property (@(posedge clk) disable iff (rst) // R07
    !fixed_src.timer |=>
    !irq_out[0])
    else $error("number 0 raised without the timer");

  keyboard_map_a: assert property (@(posedge clk) disable iff (rst) // R07
    1'b1 |=>
    irq_out[1] == $past(fixed_src.keyboard))
    else $error("number 1 not owned by the keyboard");

  cascade_map_a: assert property (@(posedge clk) disable iff (rst) // R07
    1'b1 |=>
    irq_out[2] == $past(cascade_req))
    else $error("number 2 not owned by the cascade");

  clock_map_a: assert property (@(posedge clk) disable iff (rst) // R07
    1'b1 |=>
    irq_out[8] == $past(fixed_src.rtc))
    else $error("number 8 not owned by the clock");

  coproc_map_a: assert property (@(posedge clk) disable iff (rst) // R07
    1'b1 |=>
    irq_out[13] == $past(fixed_src.coproc))
    else $error("number 13 not owned by the coprocessor");

  second_serial_a: assert property (@(posedge clk) disable iff (rst) // R08
    port_src.second_serial_port && port_src.second_serial_irq == SECOND_SERIAL_DEFAULT |=>
    irq_out[3])
    else $error("second serial port not delivered");

  parallel_default_a: assert property (@(posedge clk) disable iff (rst) // R08
    port_src.first_parallel_port && port_src.first_parallel_irq == FIRST_PARALLEL_DEFAULT |=>
    irq_out[7])
    else $error("parallel port not delivered");

  diskette_map_a: assert property (@(posedge clk) disable iff (rst) // R01
    fixed_src.diskette |=>
    irq_out[6])
    else $error("diskette not on number 6");

  mouse_map_a: assert property (@(posedge clk) disable iff (rst) // R01
    fixed_src.mouse |=>
    irq_out[12])
    else $error("mouse not on number 12");

  ide_primary_a: assert property (@(posedge clk) disable iff (rst) // R01
    fixed_src.ide_primary |=>
    irq_out[14])
    else $error("primary disk not on number 14");

  ide_secondary_a: assert property (@(posedge clk) disable iff (rst) // R01
    fixed_src.ide_secondary |=>
    irq_out[15])
    else $error("secondary disk not on number 15");

  // Per-line checks of the steering table and of legacy delivery
  for (genvar i = 0; i < LINES; i++) begin : g_line_chk
    line_steer_a: assert property (@(posedge clk) disable iff (rst) // R05
      mode == PIRR_MODE_LEGACY && line_req[i] |=>
      irq_out[$past(steer_reg[i])])
      else $error("line not on its steered number");
    steer_range_a: assert property (@(posedge clk) disable iff (rst) // R05
      1'b1 |->
      LEGACY_STEER_MASK[steer_reg[i]])
      else $error("steering holds a reserved number");
    steer_keep_a: assert property (@(posedge clk) disable iff (rst) // R05
      !(steer_wr.valid && steer_wr.line == i) |=>
      $stable(steer_reg[i]))
      else $error("steering changed without a write");
    steer_default_a: assert property (@(posedge clk) disable iff (rst) // R05
      $past(rst) |->
      steer_reg[i] == LINE_STEER_DEFAULT)
      else $error("steering default missing after reset");
  end

endmodule

// >>> test/pirr_src_model.sv
// Model of PCI interrupt sources wired onto the shared request lines
`timescale 1ns/1ps
module pirr_src_model (
  // Four sources per line, active high
  input wire logic [31:0] src_req,
  // Lines with pull-up, pulled low by any source
  output logic [7:0] line_n
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      line_n[i] = ~|src_req[4*i +: 4];
    end
  end
endmodule

// >>> test/testbench.sv
// Self-checking testbench for the shared request line router
`timescale 1ns/1ps
module testbench;
  import pirr_pkg::*;
  logic clk = 0;
  logic rst = 1;
  pirr_mode_e mode = PIRR_MODE_LEGACY;
  pirr_steer_s steer_wr = '0;
  pirr_fixed_s fixed_src = '0;
  pirr_port_s port_src = '0;
  logic cascade_req = 0;
  logic [31:0] src_req = '0;
  logic [7:0] line_n;
  logic [7:0] line_active;
  logic [23:0] irq_out;
  logic steer_err;
  int failures = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  pirr_src_model u_src (.src_req(src_req), .line_n(line_n));
  pirr_router u_dut (.clk(clk), .rst(rst), .mode(mode), .steer_wr(steer_wr), .shared_request_line_n(line_n),
    .fixed_src(fixed_src), .port_src(port_src), .cascade_req(cascade_req), .irq_out(irq_out),
    .line_active(line_active), .steer_err(steer_err));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic steer(input logic [2:0] ln, input logic [3:0] q);
    @(posedge clk) steer_wr <= '{1'b1, ln, q};
    @(posedge clk) steer_wr <= '0;
    #1;
  endtask
  task automatic req(input logic [31:0] v);
    @(posedge clk) src_req <= v;
    tick(3);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic test_fixed;
    chk("irq after reset", irq_out, 24'h000000);
    @(posedge clk) begin
      fixed_src <= 8'hff;
      cascade_req <= 1'b1;
    end
    tick(1);
    chk("fixed map", irq_out, 24'h00f147);
    @(posedge clk) port_src <= '{1'b1, 1'b1, 1'b1, 4'h4, 4'h3, 4'h7};
    @(posedge clk) begin
      fixed_src <= '0;
      cascade_req <= 1'b0;
    end
    tick(1);
    chk("port defaults", irq_out, 24'h000098);
    @(posedge clk) port_src <= '{1'b1, 1'b1, 1'b1, 4'h5, 4'h9, 4'ha};
    tick(1);
    chk("ports moved", irq_out, 24'h000620);
    @(posedge clk) port_src <= '0;
    tick(1);
    $display("test fixed done");
  endtask
  task automatic test_steer;
    logic [3:0] ok[11] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
    logic [3:0] bad[5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'hd};
    foreach (ok[i]) begin
      steer(3'h0, ok[i]);
      chk("no err", {23'h0, steer_err}, 24'h0);
      req(32'h1);
      chk("line a steered", irq_out, 24'h1 << ok[i]);
      req(32'h0);
    end
    foreach (bad[i]) begin
      steer(3'h1, bad[i]);
      chk("illegal refused", {23'h0, steer_err}, 24'h1);
    end
    req(32'h10);
    chk("line b unchanged", irq_out, 24'h000800);
    req(32'h0);
    $display("test steer done");
  endtask
  task automatic test_merge;
    steer(3'h2, 4'h9);
    steer(3'h3, 4'h9);
    req(32'h1100);
    chk("merged", irq_out, 24'h000200);
    req(32'h1000);
    chk("merged one left", irq_out, 24'h000200);
    chk("line d active", {16'h0, line_active}, 24'h000008);
    req(32'h30000);
    req(32'h20000);
    chk("shared line held", irq_out, 24'h000800);
    req(32'h0);
    chk("all released", irq_out, 24'h000000);
    $display("test merge done");
  endtask
  task automatic test_adv;
    @(posedge clk) mode <= PIRR_MODE_ADVANCED;
    for (int i = 0; i < 8; i++) begin
      req(32'h1 << (4 * i + i % 4));
      chk("advanced line", irq_out, 24'h010000 << i);
      chk("line active", {16'h0, line_active}, 24'h1 << i);
      req(32'h0);
    end
    @(posedge clk) mode <= PIRR_MODE_LEGACY;
    req(32'hffffffff);
    chk("legacy top clear", {irq_out[23:16], 16'h0}, 24'h0);
    chk("legacy all lines", irq_out, 24'h008a00);
    req(32'h0);
    $display("test advanced done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    test_fixed();
    test_steer();
    test_merge();
    test_adv();
    finish_test();
  end
  initial begin
    #50000;
    failures++;
    finish_test();
  end
endmodule
